// ==== pkg/iwd_pkg.sv ====
// constants, field layouts and types for the instruction word decoder
package iwd_pkg;

    // ----------------------------------------------------------------
    // word layout
    // ----------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam int OPC_W = 8;
    localparam int OPC_MSB = 23;
    localparam int OPC_LSB = 16;
    localparam int DWORD_W = 48;
    localparam int REG_W = 4;
    localparam int AMODE_W = 3;
    localparam int LIT_W = 16;
    localparam int FADR_W = 13;
    localparam int PADR_W = 23;
    localparam int BIT_W = 4;
    localparam int TMODE_W = 2;
    localparam int CYC_W = 2;

    // operand field positions
    localparam int BASE_LSB = 15;
    localparam int AD_LSB = 11;
    localparam int DEST_LSB = 7;
    localparam int AS_LSB = 4;
    localparam int SEC_LSB = 0;
    localparam int BITNUM_LSB = 12;
    localparam int BITIND_POS = 11;
    localparam int FDEST_POS = 13;
    localparam int LITW_LSB = 4;
    localparam int TMODE_LSB = 14;
    localparam int MODSEL_POS = 15;

    // ----------------------------------------------------------------
    // opcodes (upper byte of the word)
    // ----------------------------------------------------------------
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_CALL2W = 8'h02;
    localparam logic [7:0] OPC_GOTO2W = 8'h04;
    localparam logic [7:0] OPC_MOVD2W = 8'h08;
    localparam logic [7:0] OPC_CALLI = 8'h01;
    localparam logic [7:0] OPC_GOTOI = 8'h03;
    localparam logic [7:0] OPC_RETURN = 8'h06;
    localparam logic [7:0] OPC_INTRET = 8'h07;
    localparam logic [7:0] OPC_JUMP = 8'h37;
    localparam logic [7:0] OPC_JUMP_CALC = 8'h05;
    localparam logic [7:0] OPC_TBL_LO = 8'hBA;
    localparam logic [7:0] OPC_TBL_HI = 8'hBB;
    localparam logic [7:0] OPC_MOVLIT_LO = 8'h20;
    localparam logic [7:0] OPC_MOVLIT_HI = 8'h2F;
    localparam logic [7:0] OPC_CBR_LO = 8'h30;
    localparam logic [7:0] OPC_CBR_HI = 8'h36;
    localparam logic [7:0] OPC_REGOP_LO = 8'h40;
    localparam logic [7:0] OPC_REGOP_HI = 8'h7F;
    localparam logic [7:0] OPC_BIT_LO = 8'hA0;
    localparam logic [7:0] OPC_BIT_HI = 8'hAF;
    localparam logic [7:0] OPC_FREG_LO = 8'hB0;
    localparam logic [7:0] OPC_FREG_HI = 8'hB9;
    localparam logic [7:0] OPC_SHIFT_LO = 8'hD0;
    localparam logic [7:0] OPC_SHIFT_HI = 8'hDF;
    localparam logic [7:0] OPC_SKIP_LO = 8'hE0;
    localparam logic [7:0] OPC_SKIP_HI = 8'hE7;

    localparam logic [3:0] DEFAULT_ALIAS_REG = 4'h0;

    // cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        IWD_CAT_NOP,
        IWD_CAT_REGOP,
        IWD_CAT_FREG,
        IWD_CAT_BIT,
        IWD_CAT_LITMOV,
        IWD_CAT_LITALU,
        IWD_CAT_CTRL
    } iwd_cat_t;

endpackage : iwd_pkg

// ==== src/iwd_decoder.sv ====
// instruction word decoder with two-word gathering and cycle counting
`timescale 1ns/1ps
`default_nettype none

module iwd_decoder (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_word_valid,
    input wire logic [23:0] i_word,
    input wire logic i_cond_true,
    input wire logic i_pc_changed,
    input wire logic i_next_is_two_word,
    output logic o_two_word_flag,
    output logic o_dec_valid,
    output logic [47:0] o_instr_bits,
    output logic [7:0] o_opcode,
    output logic [2:0] o_category,
    output logic o_is_nop,
    output logic [3:0] o_base_source_register,
    output logic [3:0] o_second_source_register,
    output logic [3:0] o_destination_register,
    output logic o_dest_separate,
    output logic [2:0] o_src_amode,
    output logic [2:0] o_dst_amode,
    output logic [12:0] o_file_addr,
    output logic o_file_dest_alias,
    output logic [3:0] o_bit_pos,
    output logic o_bit_indirect,
    output logic [15:0] o_literal,
    output logic [22:0] o_prog_addr,
    output logic [1:0] o_table_mode,
    output logic [1:0] o_cycles
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    function automatic logic is_two_word(input logic [7:0] op);
        is_two_word = (op == iwd_pkg::OPC_CALL2W) || (op == iwd_pkg::OPC_GOTO2W)
            || (op == iwd_pkg::OPC_MOVD2W);
    endfunction : is_two_word

    function automatic logic is_long_single(input logic [7:0] op);
        is_long_single = (op == iwd_pkg::OPC_JUMP) || (op == iwd_pkg::OPC_JUMP_CALC)
            || (op == iwd_pkg::OPC_CALLI) || (op == iwd_pkg::OPC_GOTOI)
            || (op == iwd_pkg::OPC_RETURN) || (op == iwd_pkg::OPC_INTRET)
            || in_range(op, iwd_pkg::OPC_TBL_LO, iwd_pkg::OPC_TBL_HI);
    endfunction : is_long_single

    // ----------------------------------------------------------------
    // field split of the incoming word
    // ----------------------------------------------------------------
    logic [7:0] f_op;
    logic [3:0] f_base;
    logic [3:0] f_sec;
    logic [3:0] f_dest;
    logic [2:0] f_as;
    logic [2:0] f_ad;
    logic [3:0] f_bit;
    logic f_bind;
    logic [12:0] f_fadr;
    logic f_fdest;
    logic [15:0] f_lit;
    logic [1:0] f_tmode;
    logic f_upper_zero;

    iwd_field_split u_split (
        .i_word(i_word),
        .o_opcode(f_op),
        .o_base_source_register(f_base),
        .o_second_source_register(f_sec),
        .o_destination_register(f_dest),
        .o_src_amode(f_as),
        .o_dst_amode(f_ad),
        .o_bit_pos(f_bit),
        .o_bit_indirect(f_bind),
        .o_file_addr(f_fadr),
        .o_file_dest_is_file(f_fdest),
        .o_literal(f_lit),
        .o_table_mode(f_tmode),
        .o_upper_zero(f_upper_zero)
    );

    // ----------------------------------------------------------------
    // two-word gathering state
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {IWD_ST_FIRST, IWD_ST_SECOND} iwd_state_t;
    iwd_state_t state_r;
    logic [23:0] first_word_r;

    logic first_two;
    assign first_two = (state_r == IWD_ST_FIRST) && i_word_valid && is_two_word(f_op);
    assign o_two_word_flag = first_two;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_r <= IWD_ST_FIRST;
        end else if (i_word_valid) begin
            case (state_r)
                IWD_ST_FIRST: state_r <= first_two ? IWD_ST_SECOND : IWD_ST_FIRST;
                IWD_ST_SECOND: state_r <= IWD_ST_FIRST;
                default: state_r <= IWD_ST_FIRST;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            first_word_r <= 24'h000000;
        end else if (first_two) begin
            first_word_r <= i_word;
        end
    end

    // ----------------------------------------------------------------
    // combinational decode of the word being issued
    // ----------------------------------------------------------------
    logic issue;
    logic [7:0] opc;
    logic [2:0] cat_nxt;
    logic [1:0] cyc_nxt;
    logic dsep_nxt;
    logic [47:0] bits_nxt;

    assign issue = i_word_valid && !first_two;
    assign opc = (state_r == IWD_ST_SECOND) ? first_word_r[iwd_pkg::OPC_MSB:iwd_pkg::OPC_LSB] : f_op;
    assign bits_nxt = (state_r == IWD_ST_SECOND) ? {first_word_r, i_word} : {i_word, 24'h000000};

    always_comb begin
        cat_nxt = 3'(iwd_pkg::IWD_CAT_NOP);
        if (state_r == IWD_ST_SECOND || is_long_single(opc)) begin
            cat_nxt = 3'(iwd_pkg::IWD_CAT_CTRL);
        end else if (f_upper_zero) begin
            cat_nxt = 3'(iwd_pkg::IWD_CAT_NOP);
        end else if (in_range(opc, iwd_pkg::OPC_MOVLIT_LO, iwd_pkg::OPC_MOVLIT_HI)) begin
            cat_nxt = 3'(iwd_pkg::IWD_CAT_LITMOV);
        end else if (in_range(opc, iwd_pkg::OPC_CBR_LO, iwd_pkg::OPC_CBR_HI)) begin
            cat_nxt = 3'(iwd_pkg::IWD_CAT_CTRL);
        end else if (in_range(opc, iwd_pkg::OPC_REGOP_LO, iwd_pkg::OPC_REGOP_HI)
                     || in_range(opc, iwd_pkg::OPC_SHIFT_LO, iwd_pkg::OPC_SHIFT_HI)) begin
            cat_nxt = i_word[iwd_pkg::MODSEL_POS] ? 3'(iwd_pkg::IWD_CAT_LITALU)
                                                  : 3'(iwd_pkg::IWD_CAT_REGOP);
        end else if (in_range(opc, iwd_pkg::OPC_BIT_LO, iwd_pkg::OPC_BIT_HI)
                     || in_range(opc, iwd_pkg::OPC_SKIP_LO, iwd_pkg::OPC_SKIP_HI)) begin
            cat_nxt = 3'(iwd_pkg::IWD_CAT_BIT);
        end else if (in_range(opc, iwd_pkg::OPC_FREG_LO, iwd_pkg::OPC_FREG_HI)) begin
            cat_nxt = 3'(iwd_pkg::IWD_CAT_FREG);
        end else begin
            cat_nxt = 3'(iwd_pkg::IWD_CAT_NOP);
        end
    end

    // literal ALU: destination only separate when it differs from base
    assign dsep_nxt = (f_dest != f_base);

    always_comb begin
        cyc_nxt = iwd_pkg::CYC_ONE;
        if (state_r == IWD_ST_SECOND) begin
            cyc_nxt = iwd_pkg::CYC_TWO;
        end else if (f_upper_zero) begin
            cyc_nxt = iwd_pkg::CYC_ONE;
        end else if (in_range(opc, iwd_pkg::OPC_SKIP_LO, iwd_pkg::OPC_SKIP_HI) && i_cond_true) begin
            cyc_nxt = i_next_is_two_word ? iwd_pkg::CYC_THREE : iwd_pkg::CYC_TWO;
        end else if (is_long_single(opc)) begin
            cyc_nxt = (opc == iwd_pkg::OPC_JUMP || i_cond_true) ? iwd_pkg::CYC_TWO
                                                             : iwd_pkg::CYC_THREE;
        end else if (i_cond_true || i_pc_changed) begin
            cyc_nxt = iwd_pkg::CYC_TWO;
        end
    end

    // ----------------------------------------------------------------
    // registered decode outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_dec_valid <= 1'b0;
        end else begin
            o_dec_valid <= issue;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_instr_bits <= 48'h000000000000;
            o_opcode <= 8'h00;
            o_category <= 3'h0;
            o_is_nop <= 1'b1;
            o_cycles <= iwd_pkg::CYC_ONE;
            o_dest_separate <= 1'b0;
        end else if (issue) begin
            o_instr_bits <= bits_nxt;
            o_opcode <= opc;
            o_category <= cat_nxt;
            o_is_nop <= (state_r == IWD_ST_FIRST) && f_upper_zero;
            o_cycles <= cyc_nxt;
            o_dest_separate <= dsep_nxt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_base_source_register <= 4'h0;
            o_second_source_register <= 4'h0;
            o_destination_register <= 4'h0;
            o_src_amode <= 3'h0;
            o_dst_amode <= 3'h0;
        end else if (issue) begin
            o_base_source_register <= f_base;
            o_second_source_register <= f_sec;
            o_destination_register <= (cat_nxt == 3'(iwd_pkg::IWD_CAT_LITALU) && !dsep_nxt)
                                      ? f_base : f_dest;
            o_src_amode <= f_as;
            o_dst_amode <= f_ad;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_file_addr <= 13'h0000;
            o_file_dest_alias <= 1'b0;
            o_bit_pos <= 4'h0;
            o_bit_indirect <= 1'b0;
            o_literal <= 16'h0000;
            o_prog_addr <= 23'h000000;
            o_table_mode <= 2'h0;
        end else if (issue) begin
            o_file_addr <= f_fadr;
            o_file_dest_alias <= !f_fdest;
            o_bit_pos <= f_bind ? f_base : f_bit;
            o_bit_indirect <= f_bind;
            o_literal <= f_lit;
            o_prog_addr <= (state_r == IWD_ST_SECOND)
                           ? {i_word[6:0], first_word_r[15:0]}
                           : {7'h00, f_lit};
            o_table_mode <= f_tmode;
        end
    end
endmodule : iwd_decoder

`default_nettype wire

// ==== src/iwd_field_split.sv ====
// operand field extractor for one instruction word
`timescale 1ns/1ps
`default_nettype none

module iwd_field_split (
    input wire logic [23:0] i_word,
    output logic [7:0] o_opcode,
    output logic [3:0] o_base_source_register,
    output logic [3:0] o_second_source_register,
    output logic [3:0] o_destination_register,
    output logic [2:0] o_src_amode,
    output logic [2:0] o_dst_amode,
    output logic [3:0] o_bit_pos,
    output logic o_bit_indirect,
    output logic [12:0] o_file_addr,
    output logic o_file_dest_is_file,
    output logic [15:0] o_literal,
    output logic [1:0] o_table_mode,
    output logic o_upper_zero
);
    assign o_opcode = i_word[iwd_pkg::OPC_MSB:iwd_pkg::OPC_LSB];
    assign o_base_source_register = i_word[iwd_pkg::BASE_LSB +: iwd_pkg::REG_W];
    assign o_second_source_register = i_word[iwd_pkg::SEC_LSB +: iwd_pkg::REG_W];
    assign o_destination_register = i_word[iwd_pkg::DEST_LSB +: iwd_pkg::REG_W];
    assign o_src_amode = i_word[iwd_pkg::AS_LSB +: iwd_pkg::AMODE_W];
    assign o_dst_amode = i_word[iwd_pkg::AD_LSB +: iwd_pkg::AMODE_W];
    assign o_bit_pos = i_word[iwd_pkg::BITNUM_LSB +: iwd_pkg::BIT_W];
    assign o_bit_indirect = i_word[iwd_pkg::BITIND_POS];
    assign o_file_addr = i_word[iwd_pkg::FADR_W-1:0];
    assign o_file_dest_is_file = i_word[iwd_pkg::FDEST_POS];
    assign o_literal = i_word[iwd_pkg::LITW_LSB +: iwd_pkg::LIT_W];
    assign o_table_mode = i_word[iwd_pkg::TMODE_LSB +: iwd_pkg::TMODE_W];
    assign o_upper_zero = (i_word[iwd_pkg::OPC_MSB:iwd_pkg::OPC_LSB] == iwd_pkg::OPC_NOP);
endmodule : iwd_field_split

`default_nettype wire

// ==== tb/iwd_decoder_properties.sv ====
// concurrent checks on the instruction word decoder ports
`timescale 1ns/1ps
`default_nettype none

module iwd_decoder_properties (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_word_valid,
    input wire logic [23:0] i_word,
    input wire logic i_cond_true,
    input wire logic i_pc_changed,
    input wire logic i_next_is_two_word,
    input wire logic o_two_word_flag,
    input wire logic o_dec_valid,
    input wire logic [47:0] o_instr_bits,
    input wire logic o_is_nop,
    input wire logic [3:0] o_base_source_register,
    input wire logic [12:0] o_file_addr,
    input wire logic o_file_dest_alias,
    input wire logic [1:0] o_cycles
);
    logic pend_r;
    logic [7:0] op;
    assign op = i_word[23:16];

    // tracks whether the next valid word is an operand word
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pend_r <= 1'b0;
        end else if (i_word_valid) begin
            pend_r <= o_two_word_flag;
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_first;
        i_word_valid && !pend_r;
    endsequence
    sequence s_pair;
        i_word_valid && o_two_word_flag ##1 i_word_valid;
    endsequence

    chk_flag_match: assert property (i_word_valid |-> o_two_word_flag == (!pend_r && (op == 8'h02 || op == 8'h04 || op == 8'h08)))
        else $error("two word flag disagrees with opcode");
    chk_first_quiet: assert property (i_word_valid && o_two_word_flag |=> !o_dec_valid)
        else $error("answer after first word of a pair");
    chk_pair_bits: assert property (s_pair |=> o_dec_valid && o_instr_bits == {$past(i_word, 2), $past(i_word)} && o_cycles == iwd_pkg::CYC_TWO)
        else $error("two word gather wrong");
    chk_single_bits: assert property (s_first ##0 !o_two_word_flag |=> o_dec_valid && o_instr_bits[23:0] == 24'h000000)
        else $error("single word answer wrong");
    chk_lone_nop: assert property (s_first ##0 op == 8'h00 |=> o_is_nop && o_cycles == iwd_pkg::CYC_ONE)
        else $error("lone operand word not a no-op");
    chk_skip_cost: assert property (s_first ##0 (op >= 8'hE0 && op <= 8'hE7 && i_cond_true) |=> o_cycles == ($past(i_next_is_two_word) ? iwd_pkg::CYC_THREE : iwd_pkg::CYC_TWO))
        else $error("taken skip cycle count wrong");
    chk_plain_cost: assert property (s_first ##0 (op >= 8'h40 && op <= 8'h7F) |=> o_cycles == (($past(i_cond_true) || $past(i_pc_changed)) ? iwd_pkg::CYC_TWO : iwd_pkg::CYC_ONE))
        else $error("register op cycle count wrong");
    chk_branch_cost: assert property (s_first ##0 op == 8'h37 |=> o_cycles == iwd_pkg::CYC_TWO)
        else $error("branch cycle count wrong");
    chk_reg_fields: assert property (s_first ##0 (op >= 8'h40 && op <= 8'h7F) |=> o_base_source_register == o_instr_bits[42:39])
        else $error("base register field wrong");
    chk_file_alias: assert property (s_first ##0 (op >= 8'hB0 && op <= 8'hB9) |=> o_file_addr == o_instr_bits[36:24] && o_file_dest_alias == !o_instr_bits[37])
        else $error("file operand decode wrong");
endmodule : iwd_decoder_properties

bind iwd_decoder iwd_decoder_properties chk (.i_clk_sys, .i_rst, .i_word_valid, .i_word, .i_cond_true, .i_pc_changed,
    .i_next_is_two_word, .o_two_word_flag, .o_dec_valid, .o_instr_bits, .o_is_nop, .o_base_source_register,
    .o_file_addr, .o_file_dest_alias, .o_cycles);

`default_nettype wire

// ==== tb/iwd_fetch_model.sv ====
// program memory fetch model issuing one instruction per request
`timescale 1ns/1ps
`default_nettype none

module iwd_fetch_model (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [23:0] i_first,
    input wire logic [23:0] i_second,
    input wire logic i_two_word_flag,
    output logic o_word_valid,
    output logic [23:0] o_word
);
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_word_valid <= 1'b0;
            o_word <= 24'h000000;
        end else if (i_go) begin
            o_word_valid <= 1'b1;
            o_word <= i_first;
        end else if (o_word_valid && i_two_word_flag) begin
            // operand word follows straight away
            o_word <= i_second;
        end else begin
            // released bus shows a changing pattern
            o_word_valid <= 1'b0;
            o_word <= ~o_word;
        end
    end
endmodule : iwd_fetch_model

`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the instruction word decoder
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic go = 1'b0;
    logic cond = 1'b0;
    logic pcc = 1'b0;
    logic nxt = 1'b0;
    logic [23:0] w1 = 24'h000000;
    logic [23:0] w2 = 24'h000000;
    logic word_valid, two_word, dec_valid, is_nop, dest_sep, file_alias, bit_ind;
    logic [23:0] word;
    logic [47:0] bits;
    logic [7:0] opc;
    logic [2:0] cat, samode, damode;
    logic [3:0] base, second, dest, bitpos;
    logic [12:0] faddr;
    logic [15:0] lit;
    logic [22:0] paddr;
    logic [1:0] tmode, cyc;
    int fails = 0;
    int checked = 0;

    always #5 i_clk_sys = ~i_clk_sys;

    iwd_fetch_model fetch (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_go(go), .i_first(w1), .i_second(w2),
        .i_two_word_flag(two_word), .o_word_valid(word_valid), .o_word(word));

    iwd_decoder dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_word_valid(word_valid), .i_word(word),
        .i_cond_true(cond), .i_pc_changed(pcc), .i_next_is_two_word(nxt), .o_two_word_flag(two_word),
        .o_dec_valid(dec_valid), .o_instr_bits(bits), .o_opcode(opc), .o_category(cat), .o_is_nop(is_nop),
        .o_base_source_register(base), .o_second_source_register(second), .o_destination_register(dest),
        .o_dest_separate(dest_sep), .o_src_amode(samode), .o_dst_amode(damode), .o_file_addr(faddr),
        .o_file_dest_alias(file_alias), .o_bit_pos(bitpos), .o_bit_indirect(bit_ind), .o_literal(lit),
        .o_prog_addr(paddr), .o_table_mode(tmode), .o_cycles(cyc));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic issue(input logic [23:0] a, input logic [23:0] b, input logic c, input logic p, input logic n);
        int k;
        @(posedge i_clk_sys);
        go <= 1'b1;
        w1 <= a;
        w2 <= b;
        cond <= c;
        pcc <= p;
        nxt <= n;
        @(posedge i_clk_sys);
        go <= 1'b0;
        #1;
        for (k = 0; k < 8 && dec_valid !== 1'b1; k++) begin
            @(posedge i_clk_sys);
            #1;
        end
        check("answer", dec_valid, 1'b1);
    endtask : issue

    task automatic t_reset;
        check("reset", {dec_valid, is_nop, cyc, bits}, {1'b0, 1'b1, iwd_pkg::CYC_ONE, 48'h000000000000});
    endtask : t_reset

    task automatic t_regop;
        issue(24'h443A53, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("regop", {cat, base, second, dest, samode, damode, dest_sep, cyc},
            {3'h1, 4'h8, 4'h3, 4'h4, 3'h5, 3'h7, 1'b1, 2'h1});
        check("opcode", opc, 8'h44);
        issue(24'h443A53, 24'h000000, 1'b1, 1'b0, 1'b0);
        check("regop cond", cyc, iwd_pkg::CYC_TWO);
        issue(24'h443A53, 24'h000000, 1'b0, 1'b1, 1'b0);
        check("regop pc", cyc, iwd_pkg::CYC_TWO);
        issue(24'hD43A53, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("shift", {cat, base, cyc}, {3'h1, 4'h8, 2'h1});
    endtask : t_regop

    task automatic t_litalu;
        issue(24'h448480, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("litalu same", {cat, dest_sep, lit}, {3'h5, 1'b0, 16'h4848});
        issue(24'h448180, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("litalu other", {cat, dest_sep, dest, lit}, {3'h5, 1'b1, 4'h3, 16'h4818});
    endtask : t_litalu

    task automatic t_two_word;
        logic [7:0] ops [3] = '{8'h08, 8'h04, 8'h02};
        foreach (ops[i]) begin
            issue({ops[i], 16'h1234}, 24'h000056, 1'b0, 1'b0, 1'b0);
            check("pair bits", bits, {ops[i], 16'h1234, 24'h000056});
            check("pair cycles", {opc, cyc}, {ops[i], iwd_pkg::CYC_TWO});
        end
        check("pair target", {cat, paddr}, {3'h6, 7'h56, 16'h1234});
    endtask : t_two_word

    task automatic t_lone_nop;
        issue(24'h00ABCD, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("lone nop", {is_nop, cat, cyc, bits}, {1'b1, 3'h0, 2'h1, 24'h00ABCD, 24'h000000});
    endtask : t_lone_nop

    task automatic t_long;
        logic [7:0] ops [7] = '{8'h01, 8'h03, 8'h06, 8'h07, 8'h05, 8'hBA, 8'hBB};
        foreach (ops[i]) begin
            issue({ops[i], 16'h0000}, 24'h000000, 1'b0, 1'b0, 1'b0);
            check("long slow", cyc, iwd_pkg::CYC_THREE);
            issue({ops[i], 16'h0000}, 24'h000000, 1'b1, 1'b0, 1'b0);
            check("long fast", cyc, iwd_pkg::CYC_TWO);
        end
        issue(24'h370000, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("branch", {cat, cyc}, {3'h6, iwd_pkg::CYC_TWO});
    endtask : t_long

    task automatic t_skip;
        issue(24'hE30000, 24'h000000, 1'b1, 1'b0, 1'b0);
        check("skip one", cyc, iwd_pkg::CYC_TWO);
        issue(24'hE30000, 24'h000000, 1'b1, 1'b0, 1'b1);
        check("skip two", cyc, iwd_pkg::CYC_THREE);
        issue(24'hE30000, 24'h000000, 1'b0, 1'b0, 1'b1);
        check("skip not", cyc, iwd_pkg::CYC_ONE);
        issue(24'h330000, 24'h000000, 1'b1, 1'b0, 1'b0);
        check("cond branch", {cat, cyc}, {3'h6, iwd_pkg::CYC_TWO});
    endtask : t_skip

    task automatic t_fields;
        issue(24'hB00ABC, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("file alias", {cat, faddr, file_alias}, {3'h2, 13'h0ABC, 1'b1});
        issue(24'hB02ABC, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("file self", {faddr, file_alias}, {13'h0ABC, 1'b0});
        issue(24'hA05000, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("bit literal", {cat, bitpos, bit_ind}, {3'h3, 4'h5, 1'b0});
        issue(24'hA48800, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("bit indirect", {cat, bitpos, bit_ind}, {3'h3, 4'h9, 1'b1});
        issue(24'h2ABCD0, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("lit move", {cat, lit}, {3'h4, 16'hABCD});
        check("lit addr", paddr, 23'h00ABCD);
        issue(24'hBAC000, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("table mode", tmode, 2'h3);
        issue(24'hBB4000, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("table mode", tmode, 2'h1);
    endtask : t_fields

    task automatic summarize;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        t_reset();
        t_regop();
        t_litalu();
        t_two_word();
        t_lone_nop();
        t_long();
        t_skip();
        t_fields();
        summarize();
    end

    // about 40 instructions of a few cycles each
    initial begin
        repeat (2000) @(posedge i_clk_sys);
        fails++;
        summarize();
    end
endmodule : tb_top

`default_nettype wire
